// ===== core/bslc_defs.svh
`ifndef BSLC_DEFS_SVH
`define BSLC_DEFS_SVH

// Reference divider: the servo frequency is the reference over 8192
`define BSLC_REF_DIV_W 13
`define BSLC_REF_DIV_LAST 13'h1fff

// Period counter in reference ticks
`define BSLC_CNT_W 16
`define BSLC_CNT_MAX 16'hffff
`define BSLC_TARGET 16'h2000
// 6.25 percent of 8192 ticks
`define BSLC_LOCK_BAND 16'h0200
`define BSLC_LOCK_LO (`BSLC_TARGET - `BSLC_LOCK_BAND)
`define BSLC_LOCK_HI (`BSLC_TARGET + `BSLC_LOCK_BAND)
// Two feedback periods at the set speed
`define BSLC_PAIR_TARGET 17'h04000

// Duty and PWM counter width
`define BSLC_DUTY_W 13

// Synchronised input vector layout
`define BSLC_IN_W 10
`define BSLC_IN_OSC 0
`define BSLC_IN_FG 1
`define BSLC_IN_HALL_LSB 2
`define BSLC_IN_HALL_MSB 4
`define BSLC_IN_DIR 5
`define BSLC_IN_STOP 6
`define BSLC_IN_ILIM 7
`define BSLC_IN_PROT 8
`define BSLC_IN_LDPIN 9

// Register map
`define BSLC_ADDR_W 8
`define BSLC_DATA_W 32
`define BSLC_ADDR_STATUS 8'h00
`define BSLC_ADDR_MASK 8'h04
`define BSLC_ADDR_STATE 8'h08

// Event bits of status and mask
`define BSLC_EV_W 4
`define BSLC_EV_LOCK_GAIN 0
`define BSLC_EV_LOCK_LOST 1
`define BSLC_EV_PROTECT 2
`define BSLC_EV_OVERCUR 3

// State register fields
`define BSLC_ST_LOCKED 0
`define BSLC_ST_SHUT 1
`define BSLC_ST_RUN 2
`define BSLC_ST_DIR 3
`define BSLC_ST_LDPIN 4
`define BSLC_ST_DUTY_LSB 16

`endif

// ===== core/bslc_pkg.sv
package bslc_pkg;

   // Drive state of the whole block
   typedef enum logic [1:0]
   {
      RUN_STOP = 2'b00,
      RUN_GO = 2'b01,
      RUN_SHUT = 2'b10
   } bslc_run_t;

   // Phase detector state
   typedef enum logic [1:0]
   {
      PFD_IDLE = 2'b00,
      PFD_UP = 2'b01,
      PFD_DOWN = 2'b10
   } bslc_pfd_t;

endpackage : bslc_pkg

// ===== core/bslc_sync.sv
`timescale 1ns/10ps
`default_nettype none

module bslc_sync
#(
   parameter int WIDTH = 1
)
(
   input wire logic ref_clk, // System clock
   input wire logic rst, // Async reset, active high
   input wire logic ce, // Clock enable
   input wire logic [WIDTH-1:0] d, // Asynchronous inputs
   output logic [WIDTH-1:0] q // Synchronised outputs
);

   logic [WIDTH-1:0] meta; // First stage, read only by q

   // Two-flop synchroniser
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         meta <= '0;
         q <= '0;
      end
      else if (ce)
      begin
         meta <= d;
         q <= meta;
      end
   end

endmodule : bslc_sync

`default_nettype wire

// ===== core/bslc_top.sv
// Notes on behaviour
// - Discriminator corrects once per two feedback periods
// - Phase loop gives up/down pulse each period
// - Set feedback frequency is reference over 8192
// - Reference from crystal or external, 1-10 MHz
// - Power set by on-duty only, switches fully on
// - PWM only on low side; high side commutates
// - Current at limit cuts the on-duty
// - Within 6.25 percent is locked; indicator low
// - Outside lock band, speed error sets duty
// - Unlocked too long while running: low side off
// - Shutdown latched until stop or power cycle
// - Direction input reverses commutation, even running
// - Overcurrent after reversal: low off, high brakes
// - Direction low forward, high or open reverse
//
// Chosen here: the address-and-strobe port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "bslc_defs.svh"

module bslc_top
#(
   parameter logic [31:0] PROTECT_TICKS = 32'h0131_2d00, // Lock guard time
   parameter logic [`BSLC_DUTY_W-1:0] PWM_PERIOD = 13'h1388, // 20 kHz
   parameter logic [`BSLC_DUTY_W-1:0] START_DUTY = 13'h1388, // Duty at start
   parameter int DISC_SHIFT = 3 // Discriminator gain as right shift
)
(
   input wire logic ref_clk, // 100 MHz system clock
   input wire logic rst, // Async reset, active high
   input wire logic ce, // Clock enable, freezes state when low
   input wire logic osc_input, // Crystal or external reference
   output logic osc_output, // Inverted reference for the crystal
   input wire logic speed_feedback_pulse, // Tachometer pulses
   input wire logic [2:0] hall_in, // Hall inputs, [0] is hall_input_three
   input wire logic dir_select, // Low forward, high reverse
   input wire logic stop_req, // High stops, low runs
   input wire logic current_limit, // Overcurrent comparator
   input wire logic lock_protect_timing, // Low disables protection
   input wire logic speed_lock_indicator_i, // Lock pin level
   output logic speed_lock_indicator_o, // Lock pin drive level
   output logic speed_lock_indicator_oe, // Lock pin pulled low
   output logic [2:0] high_side, // Source switches, [0] is OUT1
   output logic [2:0] low_side, // Sink switches, [0] is OUT1
   output logic pll_up, // Phase pump up
   output logic pll_down, // Phase pump down
   input wire logic [`BSLC_ADDR_W-1:0] reg_addr, // Register address
   input wire logic [`BSLC_DATA_W-1:0] reg_wdata, // Write data
   input wire logic reg_wr, // Write strobe
   input wire logic reg_rd, // Read strobe
   output logic [`BSLC_DATA_W-1:0] reg_rdata, // Read data, one cycle late
   output logic irq // Level interrupt
);

   // Source and sink from one hall state, forward order
   function automatic logic [5:0] bslc_commute(input logic [2:0] h);
      logic [5:0] r;
      r = 6'h00;
      unique case (h)
         3'h5: r = {3'h2, 3'h1};
         3'h4: r = {3'h4, 3'h1};
         3'h6: r = {3'h4, 3'h2};
         3'h2: r = {3'h1, 3'h2};
         3'h3: r = {3'h1, 3'h4};
         3'h1: r = {3'h2, 3'h4};
         default: r = 6'h00; // All-equal halls are illegal: all off
      endcase
      return r;
   endfunction : bslc_commute

   logic [`BSLC_IN_W-1:0] pins; // Synchronised pin levels
   logic osc_q; // Previous reference level
   logic fg_q; // Previous feedback level
   logic [`BSLC_REF_DIV_W-1:0] ref_div; // Reference divider
   logic [`BSLC_CNT_W-1:0] per_cnt; // Ticks in current period
   logic [`BSLC_CNT_W-1:0] prev_per; // Ticks in last period
   logic half; // Second period of a pair
   logic locked; // Speed inside lock band
   logic [`BSLC_DUTY_W-1:0] duty; // PWM on-time in cycles
   logic [`BSLC_DUTY_W-1:0] pwm_cnt; // PWM carrier
   logic chop; // Cut by current limit
   logic [31:0] prot_cnt; // Unlocked time in ticks
   logic ilim_q; // Previous current limit level
   logic [`BSLC_EV_W-1:0] status; // Sticky events
   logic [`BSLC_EV_W-1:0] mask; // Interrupt enables
   bslc_pkg::bslc_run_t run_state; // Drive state
   bslc_pkg::bslc_run_t next_run;
   bslc_pkg::bslc_pfd_t pfd_state; // Phase detector
   bslc_pkg::bslc_pfd_t next_pfd;

   // Every pin except the register port passes two flops before use
   bslc_sync #(.WIDTH(`BSLC_IN_W)) u_sync
   (
      .ref_clk(ref_clk),
      .rst(rst),
      .ce(ce),
      .d({speed_lock_indicator_i, lock_protect_timing, current_limit,
          stop_req, dir_select, hall_in, speed_feedback_pulse, osc_input}),
      .q(pins)
   );

   // Decoded pin levels
   wire osc_s = pins[`BSLC_IN_OSC];
   wire fg_s = pins[`BSLC_IN_FG];
   wire [2:0] hall_s = pins[`BSLC_IN_HALL_MSB:`BSLC_IN_HALL_LSB];
   wire dir_s = pins[`BSLC_IN_DIR];
   wire stop_s = pins[`BSLC_IN_STOP];
   wire ilim_s = pins[`BSLC_IN_ILIM];
   wire prot_en = pins[`BSLC_IN_PROT];
   wire ldpin_s = pins[`BSLC_IN_LDPIN];

   // Reference tick: rising edge of crystal or external clock.
   // Up to 10 MHz leaves ten samples a period at 100 MHz.
   wire ref_tick = osc_s & ~osc_q;
   wire ref_edge = ref_tick & (ref_div == `BSLC_REF_DIV_LAST);
   wire fg_edge = fg_s & ~fg_q;

   // Lock band on the period; a stalled motor runs past it
   wire per_in_band = (per_cnt >= `BSLC_LOCK_LO) &&
                      (per_cnt <= `BSLC_LOCK_HI);
   wire per_over = per_cnt > `BSLC_LOCK_HI;
   wire next_locked = fg_edge ? per_in_band :
                      (per_over ? 1'b0 : locked);

   // Pair sum for the discriminator
   wire [`BSLC_CNT_W:0] pair_sum = {1'b0, prev_per} + {1'b0, per_cnt};
   wire disc_apply = fg_edge & half & ~locked;
   wire signed [19:0] disc_diff = $signed({3'h0, pair_sum}) -
                                  $signed({3'h0, `BSLC_PAIR_TARGET});
   wire signed [19:0] disc_delta = disc_apply ?
                                   (disc_diff >>> DISC_SHIFT) : 20'sh0;

   // Phase detector: reference first means motor late
   always_comb
   begin
      next_pfd = pfd_state;
      unique case (pfd_state)
         bslc_pkg::PFD_IDLE:
            if (ref_edge & ~fg_edge)
               next_pfd = bslc_pkg::PFD_UP;
            else if (fg_edge & ~ref_edge)
               next_pfd = bslc_pkg::PFD_DOWN;
         bslc_pkg::PFD_UP:
            if (fg_edge)
               next_pfd = bslc_pkg::PFD_IDLE;
         bslc_pkg::PFD_DOWN:
            if (ref_edge)
               next_pfd = bslc_pkg::PFD_IDLE;
         default: next_pfd = bslc_pkg::PFD_IDLE;
      endcase
   end

   // One duty step at the end of each pump pulse
   wire pfd_inc = (pfd_state == bslc_pkg::PFD_UP) & fg_edge;
   wire pfd_dec = (pfd_state == bslc_pkg::PFD_DOWN) & ref_edge;
   wire signed [19:0] pfd_delta = pfd_inc ? 20'sh1 :
                                  (pfd_dec ? -20'sh1 : 20'sh0);

   // Duty is the only power control; clamp to the carrier
   wire signed [19:0] duty_sum = $signed({7'h0, duty}) + disc_delta +
                                 pfd_delta;
   wire signed [19:0] duty_top = $signed({7'h0, PWM_PERIOD});
   wire [`BSLC_DUTY_W-1:0] next_duty =
      (run_state == bslc_pkg::RUN_STOP) ? START_DUTY :
      (duty_sum < 20'sh0) ? 13'h0000 :
      (duty_sum > duty_top) ? PWM_PERIOD :
      duty_sum[`BSLC_DUTY_W-1:0];

   // Wrap clears the chop, but a held limit wins: no stray pulse
   wire pwm_wrap = pwm_cnt >= (PWM_PERIOD - 13'h0001);
   wire next_chop = ilim_s | (chop & ~pwm_wrap);
   wire pwm_on = (pwm_cnt < duty) & ~next_chop;

   // Commutation, reversed by inverting the halls
   wire [2:0] hall_dir = dir_s ? ~hall_s : hall_s;
   wire [5:0] commute = bslc_commute(hall_dir);
   wire [2:0] src = commute[5:3];
   wire [2:0] snk = commute[2:0];

   // Protection timer and state
   wire prot_hit = prot_cnt >= PROTECT_TICKS;
   always_comb
   begin
      next_run = run_state;
      unique case (run_state)
         bslc_pkg::RUN_STOP:
            if (~stop_s)
               next_run = bslc_pkg::RUN_GO;
         bslc_pkg::RUN_GO:
            if (stop_s)
               next_run = bslc_pkg::RUN_STOP;
            else if (prot_hit & prot_en)
               next_run = bslc_pkg::RUN_SHUT;
         bslc_pkg::RUN_SHUT:
            if (stop_s)
               next_run = bslc_pkg::RUN_STOP;
         default: next_run = bslc_pkg::RUN_STOP;
      endcase
   end

   // Counter clears on lock, stop or disabled protection
   wire prot_clr = locked | (run_state != bslc_pkg::RUN_GO) |
                   ~prot_en;
   wire [31:0] next_prot = prot_clr ? 32'h0000_0000 :
                           ((ref_tick & ~prot_hit) ? prot_cnt + 32'h1 :
                            prot_cnt);

   // Events
   wire running = run_state != bslc_pkg::RUN_STOP;
   wire [`BSLC_EV_W-1:0] events;
   assign events[`BSLC_EV_LOCK_GAIN] = next_locked & ~locked;
   assign events[`BSLC_EV_LOCK_LOST] = ~next_locked & locked;
   assign events[`BSLC_EV_PROTECT] = (next_run == bslc_pkg::RUN_SHUT) &
                                    (run_state == bslc_pkg::RUN_GO);
   assign events[`BSLC_EV_OVERCUR] = ilim_s & ~ilim_q & running;

   // Register decode
   wire sel_status = reg_addr == `BSLC_ADDR_STATUS;
   wire sel_mask = reg_addr == `BSLC_ADDR_MASK;
   wire sel_state = reg_addr == `BSLC_ADDR_STATE;
   wire [`BSLC_EV_W-1:0] clr_bits = (reg_wr & sel_status) ?
                                    reg_wdata[`BSLC_EV_W-1:0] : '0;
   // Set wins over a clear in the same cycle
   wire [`BSLC_EV_W-1:0] next_status = (status & ~clr_bits) | events;
   wire [`BSLC_EV_W-1:0] next_mask = (reg_wr & sel_mask) ?
                                     reg_wdata[`BSLC_EV_W-1:0] : mask;
   logic [`BSLC_DATA_W-1:0] state_word; // Live state view
   always_comb
   begin
      state_word = '0;
      state_word[`BSLC_ST_LOCKED] = locked;
      state_word[`BSLC_ST_SHUT] = run_state == bslc_pkg::RUN_SHUT;
      state_word[`BSLC_ST_RUN] = run_state == bslc_pkg::RUN_GO;
      state_word[`BSLC_ST_DIR] = dir_s;
      state_word[`BSLC_ST_LDPIN] = ldpin_s;
      state_word[`BSLC_ST_DUTY_LSB +: `BSLC_DUTY_W] = duty;
   end
   // Unmapped addresses read zero
   wire [`BSLC_DATA_W-1:0] rd_mux =
      sel_status ? {{(`BSLC_DATA_W-`BSLC_EV_W){1'b0}}, status} :
      sel_mask ? {{(`BSLC_DATA_W-`BSLC_EV_W){1'b0}}, mask} :
      sel_state ? state_word : '0;

   // Edge history and reference divider
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         osc_q <= 1'b0;
         fg_q <= 1'b0;
         ilim_q <= 1'b0;
         ref_div <= '0;
      end
      else if (ce)
      begin
         osc_q <= osc_s;
         fg_q <= fg_s;
         ilim_q <= ilim_s;
         if (ref_tick)
            ref_div <= ref_div + 13'h0001;
      end
   end

   // Period measurement, saturating so a stall cannot wrap
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         per_cnt <= '0;
         prev_per <= '0;
         half <= 1'b0;
         locked <= 1'b0;
      end
      else if (ce)
      begin
         locked <= next_locked;
         if (fg_edge)
         begin
            prev_per <= per_cnt;
            half <= ~half;
            per_cnt <= ref_tick ? 16'h0001 : 16'h0000;
         end
         else if (ref_tick && per_cnt != `BSLC_CNT_MAX)
            per_cnt <= per_cnt + 16'h0001;
      end
   end

   // Loop state, duty and carrier
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         pfd_state <= bslc_pkg::PFD_IDLE;
         run_state <= bslc_pkg::RUN_STOP;
         duty <= '0;
         pwm_cnt <= '0;
         chop <= 1'b0;
         prot_cnt <= '0;
      end
      else if (ce)
      begin
         pfd_state <= next_pfd;
         run_state <= next_run;
         duty <= next_duty;
         pwm_cnt <= pwm_wrap ? 13'h0000 : pwm_cnt + 13'h0001;
         chop <= next_chop;
         prot_cnt <= next_prot;
      end
   end

   // Drive outputs, all registered
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         high_side <= 3'h0;
         low_side <= 3'h0;
         pll_up <= 1'b0;
         pll_down <= 1'b0;
         osc_output <= 1'b0;
         speed_lock_indicator_o <= 1'b0;
         speed_lock_indicator_oe <= 1'b0;
      end
      else if (ce)
      begin
         // High side only commutates and stays on in shutdown,
         // which gives the short brake after a hard reversal
         high_side <= (next_run != bslc_pkg::RUN_STOP) ? src : 3'h0;
         // Only the low side switches, cut by chop or shutdown
         low_side <= (next_run == bslc_pkg::RUN_GO) ?
                     (snk & {3{pwm_on}}) : 3'h0;
         pll_up <= next_pfd == bslc_pkg::PFD_UP;
         pll_down <= next_pfd == bslc_pkg::PFD_DOWN;
         osc_output <= ~osc_s;
         speed_lock_indicator_o <= 1'b0;
         speed_lock_indicator_oe <= next_locked;
      end
   end

   // Register bus and interrupt
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         status <= '0;
         mask <= '0;
         reg_rdata <= '0;
         irq <= 1'b0;
      end
      else if (ce)
      begin
         status <= next_status;
         mask <= next_mask;
         reg_rdata <= reg_rd ? rd_mux : '0;
         irq <= |(next_status & next_mask);
      end
   end

endmodule : bslc_top

`default_nettype wire

// ===== tb/bslc_checker.sv
`timescale 1ns/10ps
`default_nettype none

module bslc_checker
(
   input wire logic ref_clk, // Clock
   input wire logic rst, // Reset
   input wire logic stop_req, // Stop
   input wire logic [2:0] hall_in, // Halls
   input wire logic dir_select, // Direction
   input wire logic current_limit, // Overcurrent
   input wire logic speed_lock_indicator_o, // Lock level
   input wire logic osc_input, // Reference pin
   input wire logic osc_output, // Reference inverter
   input wire logic speed_feedback_pulse, // Tachometer
   input wire logic [2:0] high_side, // Sources
   input wire logic [2:0] low_side, // Sinks
   input wire logic pll_up, // Pump up
   input wire logic pll_down, // Pump down
   input wire logic speed_lock_indicator_oe // Lock pull
);
   // Source and sink per forward hall code; reverse inverts the code
   localparam logic [5:0] COMM [0:7] = '{6'h00, 6'h14, 6'h0a, 6'h0c,
      6'h21, 6'h11, 6'h22, 6'h00};
   wire logic [5:0] comm_now; // Expected pair now
   assign comm_now = COMM[hall_in ^ {3{dir_select}}];

   default clocking @(posedge ref_clk);
   endclocking
   default disable iff (rst);

   a_one_source: assert property ($onehot0(high_side))
      else $error("two source switches on");
   a_one_sink: assert property ($onehot0(low_side))
      else $error("two sink switches on");
   a_no_shoot: assert property ((high_side & low_side) == 3'h0)
      else $error("source and sink on in one phase");
   a_stop_off: assert property (stop_req [*6] |->
      (high_side | low_side) == 3'h0) else $error("switch on in stop");
   a_limit_chop: assert property (current_limit [*6] |->
      low_side == 3'h0) else $error("sink on at current limit");
   a_commute_src: assert property ((!stop_req &&
      $stable(hall_in) && $stable(dir_select)) [*6] |->
      high_side == comm_now[5:3]) else $error("wrong source switch");
   a_pump_apart: assert property (!(pll_up && pll_down))
      else $error("pump up and down together");
   a_lock_open: assert property (!speed_lock_indicator_o)
      else $error("lock pin driven high");
   // Two sync flops and the output flop: three cycles of lag
   a_osc_follow: assert property (!$past(rst) |->
      osc_output == !$past(osc_input, 3))
      else $error("reference inverter wrong");
   // Pump up ends only on a synchronised feedback rising edge
   a_pump_end: assert property ($fell(pll_up) |->
      $past(speed_feedback_pulse, 3) && !$past(speed_feedback_pulse, 4))
      else $error("pump up ended without feedback edge");

   c_lock: cover property ($rose(speed_lock_indicator_oe));
   c_up: cover property ($fell(pll_up));
   c_down: cover property ($fell(pll_down));
endmodule : bslc_checker

`default_nettype wire

// ===== tb/bslc_motor_model.sv
`timescale 1ns/10ps
`default_nettype none

module bslc_motor_model
(
   input wire logic ref_clk, // Clock
   input wire logic rst, // Reset
   input wire logic [15:0] fg_period, // Ticks per pulse, 0 stands
   output logic osc_input, // Reference
   output logic speed_feedback_pulse // Tachometer
);
   logic [15:0] tick_cnt; // Ticks since last pulse
   logic [15:0] next_cnt; // Count after this tick

   assign next_cnt = tick_cnt + 16'h0001;

   // Reference at half the system clock, scaled up to keep runs short
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         osc_input <= 1'b0;
         tick_cnt <= 16'h0000;
         speed_feedback_pulse <= 1'b0;
      end
      else
      begin
         osc_input <= ~osc_input;
         // Count rising ticks; one period is exactly fg_period ticks
         if (!osc_input)
            tick_cnt <= (next_cnt >= fg_period) ? 16'h0000 : next_cnt;
         // A stalled motor gives no pulses at all
         speed_feedback_pulse <= (fg_period != 16'h0000) &&
            (tick_cnt < 16'h0004);
      end
   end
endmodule : bslc_motor_model

`default_nettype wire

// ===== tb/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "bslc_defs.svh"

module tb_top;
   localparam logic [12:0] PERIOD = 13'h0010; // Short PWM carrier
   // Source and sink per forward hall code; reverse inverts the code
   localparam logic [5:0] COMM [0:7] = '{6'h00, 6'h14, 6'h0a, 6'h0c,
      6'h21, 6'h11, 6'h22, 6'h00};
   logic ref_clk = 1'b0; // Clock
   logic rst = 1'b1; // Reset
   logic stop_req = 1'b1; // Stop
   logic dir_select = 1'b0; // Direction
   logic current_limit = 1'b0; // Overcurrent
   logic lock_protect_timing = 1'b0; // Guard grounded
   logic [2:0] hall_in = 3'h0; // Rotor position
   logic [15:0] fg_period = 16'h0000; // Speed in ticks
   logic [7:0] reg_addr = 8'h00; // Address
   logic [31:0] reg_wdata = 32'h0000_0000; // Write data
   logic reg_wr = 1'b0; // Write strobe
   logic reg_rd = 1'b0; // Read strobe
   logic [31:0] rnd; // Random draw
   logic [5:0] exp_sw; // Expected switches
   wire logic osc_input, osc_output, speed_feedback_pulse, irq; // Pins
   wire logic speed_lock_indicator_o, speed_lock_indicator_oe; // Lock
   wire logic speed_lock_indicator_i; // Lock pin level
   wire logic pll_up, pll_down; // Pump
   wire logic [2:0] high_side, low_side; // Switches
   wire logic [31:0] reg_rdata; // Read data
   int bad_count = 0; // Mismatches
   int total_checks = 0; // Comparisons

   // Open collector with pull-up
   assign speed_lock_indicator_i = speed_lock_indicator_oe ?
      speed_lock_indicator_o : 1'b1;

   initial
   begin
      forever #5 ref_clk = ~ref_clk;
   end

   // Guard of 200 ticks, 400 cycles at this reference
   bslc_top #(.PROTECT_TICKS(32'h0000_00c8), .PWM_PERIOD(PERIOD),
      .START_DUTY(PERIOD), .DISC_SHIFT(3)) bslc_top_i
   (
      .ref_clk, .rst, .ce(1'b1), .osc_input, .osc_output,
      .speed_feedback_pulse, .hall_in, .dir_select, .stop_req,
      .current_limit, .lock_protect_timing, .speed_lock_indicator_i,
      .speed_lock_indicator_o, .speed_lock_indicator_oe, .high_side,
      .low_side, .pll_up, .pll_down, .reg_addr, .reg_wdata, .reg_wr,
      .reg_rd, .reg_rdata, .irq
   );

   bslc_motor_model bslc_motor_model_i
   (
      .ref_clk, .rst, .fg_period, .osc_input, .speed_feedback_pulse
   );

   task automatic chk(input string what, input logic [31:0] e,
      input logic [31:0] g);
      total_checks++;
      if (g !== e)
      begin
         bad_count++;
         $display("unexpected %s: expected %h seen %h", what, e, g);
      end
   endtask : chk

   // Expected source and sink; reverse inverts the hall code
   function automatic logic [5:0] exp_comm(input logic [2:0] h,
      input logic d);
      return COMM[h ^ {3{d}}];
   endfunction : exp_comm

   task automatic settle(input int n);
      repeat (n) @(posedge ref_clk);
      @(negedge ref_clk);
   endtask : settle

   task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask : reg_write

   task automatic reg_read(input logic [7:0] a, input logic [31:0] m,
      input logic [31:0] e);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      @(negedge ref_clk);
      chk($sformatf("register %h", a), e & m, reg_rdata & m);
   endtask : reg_read

   task automatic end_test(input string name);
      $display("test %s over, %0d mismatches", name, bad_count);
   endtask : end_test

   task automatic test_done();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : test_done

   // Bounded wait on the lock pin; running out ends the run
   task automatic wait_lock(input logic v, input int n);
      for (int j = 0; j < n && speed_lock_indicator_oe !== v; j++)
         @(negedge ref_clk);
      chk("lock pull", v, speed_lock_indicator_oe);
      if (speed_lock_indicator_oe !== v)
         test_done();
   endtask : wait_lock

   initial
   begin
      rnd = $urandom(32'hcfd74894);
      repeat (20) @(posedge ref_clk);
      rst <= 1'b0;
      // Reset values, read-only and unmapped places
      reg_read(`BSLC_ADDR_STATUS, 32'hffff_ffff, 32'h0);
      reg_read(`BSLC_ADDR_MASK, 32'hffff_ffff, 32'h0);
      reg_write(`BSLC_ADDR_STATE, 32'hffff_ffff);
      reg_read(`BSLC_ADDR_STATE, 32'hffff_ffff, 32'h0010_0010);
      reg_read(8'h0c, 32'hffff_ffff, 32'h0);
      rnd = $urandom;
      reg_write(`BSLC_ADDR_MASK, rnd);
      reg_read(`BSLC_ADDR_MASK, 32'hffff_ffff, rnd & 32'hf);
      reg_write(`BSLC_ADDR_MASK, 32'h0);
      end_test("registers");
      // Commutation in both directions, the six legal hall codes first
      stop_req <= 1'b0;
      for (int k = 0; k < 20; k++)
      begin
         @(posedge ref_clk);
         rnd = $urandom;
         hall_in <= (k < 6) ? 3'(k + 1) : rnd[2:0];
         dir_select <= rnd[3]; // motor is standing here
         settle(8);
         exp_sw = exp_comm(hall_in, dir_select);
         chk("source", exp_sw[5:3], high_side);
         chk("sink", exp_sw[2:0], low_side);
      end
      end_test("commutation");
      // Overcurrent chops only the sink
      @(posedge ref_clk);
      hall_in <= 3'b101;
      dir_select <= 1'b0;
      current_limit <= 1'b1;
      settle(8);
      chk("sink at limit", 32'h0, low_side);
      chk("source at limit", 32'h2, high_side);
      @(posedge ref_clk);
      current_limit <= 1'b0;
      settle(24);
      chk("sink after limit", 32'h1, low_side);
      reg_read(`BSLC_ADDR_STATUS, 32'h8, 32'h8);
      reg_write(`BSLC_ADDR_STATUS, 32'hf);
      end_test("current limit");
      // Stalled motor with guard grounded, then enabled
      settle(600);
      chk("sink unguarded", 32'h1, low_side);
      @(posedge ref_clk);
      lock_protect_timing <= 1'b1;
      settle(500);
      chk("sink guarded", 32'h0, low_side);
      chk("source brake", 32'h2, high_side);
      chk("irq masked", 32'h0, irq);
      reg_write(`BSLC_ADDR_MASK, 32'h4);
      settle(2);
      chk("irq raised", 32'h1, irq);
      reg_write(`BSLC_ADDR_STATUS, 32'h4);
      settle(2);
      chk("irq cleared", 32'h0, irq);
      reg_read(`BSLC_ADDR_STATE, 32'h2, 32'h2);
      @(posedge ref_clk);
      lock_protect_timing <= 1'b0;
      settle(50);
      chk("sink latched", 32'h0, low_side);
      @(posedge ref_clk);
      stop_req <= 1'b1;
      settle(8);
      reg_read(`BSLC_ADDR_STATE, 32'h6, 32'h0);
      @(posedge ref_clk);
      stop_req <= 1'b0;
      settle(8);
      chk("sink restarted", 32'h1, low_side);
      end_test("lock guard");
      // Stalled motor: the first reference edge leaves the pump up
      for (int j = 0; j < 17000 && pll_up !== 1'b1; j++)
         @(negedge ref_clk);
      chk("pump up", 32'h1, pll_up);
      if (pll_up !== 1'b1)
         test_done();
      // Set speed, one tick past the band, then its upper edge
      @(posedge ref_clk);
      fg_period <= 16'h2000;
      wait_lock(1'b1, 40000);
      chk("lock pin", 32'h0, speed_lock_indicator_i);
      // Pin readback passes the synchroniser first
      settle(2);
      reg_read(`BSLC_ADDR_STATE, 32'h11, 32'h1);
      reg_read(`BSLC_ADDR_STATUS, 32'h3, 32'h1);
      @(posedge ref_clk);
      fg_period <= 16'h2201;
      wait_lock(1'b0, 20000);
      reg_read(`BSLC_ADDR_STATUS, 32'h2, 32'h2);
      @(posedge ref_clk);
      fg_period <= 16'h2200;
      wait_lock(1'b1, 20000);
      end_test("speed lock");
      test_done();
   end
endmodule : tb_top

bind bslc_top bslc_checker bslc_checker_i
(
   .ref_clk, .rst, .stop_req, .hall_in, .dir_select, .current_limit,
   .speed_lock_indicator_o, .osc_input, .osc_output, .speed_feedback_pulse,
   .high_side, .low_side, .pll_up, .pll_down, .speed_lock_indicator_oe
);

`default_nettype wire
